// ==== logic/ctt_irq.sv ====
`timescale 1ns/100ps
module ctt_irq
    import ctt_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] event_in,
    input wire logic [3:0] clear_in,
    input wire logic mask_wr_in,
    input wire logic [3:0] mask_data_in,
    output logic [3:0] flags_out,
    output logic [3:0] mask_out,
    output logic irq_out
);
    logic [3:0] flag_reg;
    logic [3:0] flag_next;
    logic [3:0] mask_reg;
    logic [3:0] mask_next;
    logic irq_reg;
    logic irq_next;

    genvar i;
    generate
        for (i = 0; i < CTT_TAPS; i++) begin : g_flag
            // set beats a simultaneous write-one clear
            always_comb begin
                flag_next[i] = event_in[i] | (flag_reg[i] & ~clear_in[i]); // [R10] [R12] [R13]
            end
        end
    endgenerate

    always_comb begin
        mask_next = mask_wr_in ? mask_data_in : mask_reg; // [R11]
        irq_next = |(flag_next & mask_next); // [R9] [R11]
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            flag_reg <= CTT_FLAG_RST; // [R14]
            mask_reg <= CTT_MASK_RST; // [R14]
            irq_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    assign flags_out = flag_reg;
    assign mask_out = mask_reg;
    assign irq_out = irq_reg;

    a_flag_on_event: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R12]
        (event_in != 4'h0) |=> ((flag_reg & $past(event_in)) == $past(event_in)))
        else $error("tick flag not set by tap edge");
    a_flag_sticky: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R13]
        ##1 ((flag_reg & ~$past(flag_reg)) & ~$past(event_in)) == 4'h0)
        else $error("tick flag set without an event");
    a_irq_gated: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R11]
        irq_out == |(flag_reg & mask_reg))
        else $error("interrupt output disagrees with flags and mask");
endmodule // ctt_irq

// ==== logic/ctt_pkg.sv ====
package ctt_pkg;
    // register map, plain 16-bit address, 4-bit data
    localparam logic [15:0] CTT_ADDR_LOW = 16'hFF79;
    localparam logic [15:0] CTT_ADDR_HIGH = 16'hFF7A;
    localparam logic [15:0] CTT_ADDR_FLAG = 16'hFF7B;
    localparam logic [15:0] CTT_ADDR_MASK = 16'hFF7C;
    localparam int CTT_DATA_W = 4;
    localparam int CTT_TAPS = 4;
    // counter bit positions of the 32, 8, 2 and 1 Hz taps
    localparam int CTT_TAP_POS [CTT_TAPS] = '{2, 4, 6, 7};
    // reset values and nibble maximum
    localparam logic [3:0] CTT_NIBBLE_RST = 4'h0;
    localparam logic [3:0] CTT_FLAG_RST = 4'h0;
    localparam logic [3:0] CTT_MASK_RST = 4'h0;
    localparam logic [3:0] CTT_RDATA_RST = 4'h0;
    localparam logic [3:0] CTT_NIBBLE_MAX = 4'hF;
    localparam logic [15:0] CTT_HOLD_CNT_RST = 16'h0000;
    // timing
    localparam int unsigned CTT_CLK_PERIOD_NS = 50;
    localparam int unsigned CTT_HOLD_MAX_US = 1500;
    localparam int unsigned CTT_HOLD_MAX_CYC = (CTT_HOLD_MAX_US * 1000) / CTT_CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        CTT_ST_FREE = 2'b01,
        CTT_ST_HOLD = 2'b10
    } ctt_hold_e;
endpackage

// ==== logic/ctt_sync.sv ====
`timescale 1ns/100ps
module ctt_sync
    import ctt_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule // ctt_sync

// ==== logic/ctt_timer.sv ====
// Functional notes
// R1: count synchronised crystal prescaler ticks in binary
// R2: eight-bit binary up-counter, readable by software
// R3: low nibble at first address, 128-16 Hz
// R4: high nibble at second address, carry-driven
// R5: low read freezes high nibble, bounded time
// R6: high read ends hold, deferred carry applied
// R7: high read first never holds low nibble
// R8: software reads low nibble before high
// R9: interrupt on 32/8/2/1 Hz falling edges
// R10: falling edge sets that tap's flag
// R11: per-tap mask bit gates the request
// R12: flags set regardless of mask state
// R13: flags sticky until written with one
// R14: reset clears counter, flags and masks
`timescale 1ns/100ps
module ctt_timer
    import ctt_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = CTT_HOLD_MAX_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic crystal_tick_in,
    input wire logic [15:0] addr_in,
    input wire logic [3:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [3:0] rdata_out,
    output logic irq_out
);
    logic tick_sync;
    logic tick_prev_reg;
    logic tick_prev_next;
    logic tick_rise;

    logic [3:0] low_reg;
    logic [3:0] low_next;
    logic [3:0] high_reg;
    logic [3:0] high_next;
    logic pend_reg;
    logic pend_next;
    logic [15:0] hold_cnt_reg;
    logic [15:0] hold_cnt_next;
    ctt_hold_e state_reg;
    ctt_hold_e state_next;
    logic carry;
    logic hold_end;

    logic [7:0] prev_count_reg;
    logic [7:0] prev_count_next;
    logic [3:0] tap_fall;

    logic [3:0] rdata_reg;
    logic [3:0] rdata_next;
    logic rd_low;
    logic rd_high;
    logic rd_flag;
    logic rd_mask;
    logic wr_flag;
    logic wr_mask;
    logic [3:0] flag_clear;
    logic [3:0] flags;
    logic [3:0] mask;

    // prescaler output comes from the crystal domain, so sync it first
    ctt_sync u_tick_sync (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .async_in(crystal_tick_in),
        .sync_out(tick_sync)
    );

    always_comb begin
        tick_prev_next = tick_sync;
        tick_rise = tick_sync & ~tick_prev_reg; // [R1]
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            tick_prev_reg <= 1'b0;
        end else begin
            tick_prev_reg <= tick_prev_next;
        end
    end

    // address decode
    always_comb begin
        rd_low = 1'b0;
        rd_high = 1'b0;
        rd_flag = 1'b0;
        rd_mask = 1'b0;
        wr_flag = 1'b0;
        wr_mask = 1'b0;
        if (addr_in == CTT_ADDR_LOW) begin
            rd_low = rd_in; // [R3]
        end else if (addr_in == CTT_ADDR_HIGH) begin
            rd_high = rd_in; // [R4]
        end else if (addr_in == CTT_ADDR_FLAG) begin
            rd_flag = rd_in;
            wr_flag = wr_in;
        end else if (addr_in == CTT_ADDR_MASK) begin
            rd_mask = rd_in;
            wr_mask = wr_in;
        end
    end

    // counter and high-nibble hold
    always_comb begin
        carry = tick_rise & (low_reg == CTT_NIBBLE_MAX); // [R4]
        low_next = tick_rise ? low_reg + 4'h1 : low_reg; // [R2] [R7]
        high_next = high_reg;
        pend_next = pend_reg;
        hold_cnt_next = hold_cnt_reg;
        state_next = state_reg;
        hold_end = 1'b0;
        case (state_reg)
            CTT_ST_FREE: begin
                if (rd_low) begin
                    // a carry in the read cycle comes after the low value just read
                    state_next = CTT_ST_HOLD; // [R5]
                    hold_cnt_next = CTT_HOLD_CNT_RST;
                    pend_next = carry; // [R5]
                end else begin
                    high_next = high_reg + {3'h0, carry}; // [R4]
                end
            end
            CTT_ST_HOLD: begin
                // high-first reads stay in CTT_ST_FREE, never reach this state, and never touch low_next
                hold_end = rd_high | (hold_cnt_reg == 16'(HOLD_CYCLES - 1)); // [R5] [R6]
                if (rd_low) begin
                    hold_cnt_next = CTT_HOLD_CNT_RST;
                    pend_next = pend_reg | carry;
                end else if (hold_end) begin
                    high_next = high_reg + {3'h0, pend_reg} + {3'h0, carry}; // [R6]
                    pend_next = 1'b0;
                    state_next = CTT_ST_FREE;
                end else begin
                    hold_cnt_next = hold_cnt_reg + 16'h0001;
                    pend_next = pend_reg | carry; // [R5]
                end
            end
            default: begin
                state_next = CTT_ST_FREE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            low_reg <= CTT_NIBBLE_RST; // [R14]
            high_reg <= CTT_NIBBLE_RST; // [R14]
            pend_reg <= 1'b0;
            hold_cnt_reg <= CTT_HOLD_CNT_RST;
            state_reg <= CTT_ST_FREE;
        end else begin
            low_reg <= low_next;
            high_reg <= high_next;
            pend_reg <= pend_next;
            hold_cnt_reg <= hold_cnt_next;
            state_reg <= state_next;
        end
    end

    // tap falling edges, seen on the visible count
    always_comb begin
        prev_count_next = {high_reg, low_reg};
    end

    genvar t;
    generate
        for (t = 0; t < CTT_TAPS; t++) begin : g_tap
            assign tap_fall[t] = prev_count_reg[CTT_TAP_POS[t]]
                & ~prev_count_next[CTT_TAP_POS[t]]; // [R9] [R10]
        end
    endgenerate

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            prev_count_reg <= {CTT_NIBBLE_RST, CTT_NIBBLE_RST};
        end else begin
            prev_count_reg <= prev_count_next;
        end
    end

    always_comb begin
        flag_clear = wr_flag ? wdata_in : 4'h0; // [R13]
    end

    ctt_irq u_irq (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .event_in(tap_fall),
        .clear_in(flag_clear),
        .mask_wr_in(wr_mask),
        .mask_data_in(wdata_in),
        .flags_out(flags),
        .mask_out(mask),
        .irq_out(irq_out)
    );

    // read data valid only in the cycle after the strobe
    always_comb begin
        rdata_next = CTT_RDATA_RST;
        if (rd_low) begin
            rdata_next = low_reg; // [R3]
        end else if (rd_high) begin
            rdata_next = high_reg; // [R4]
        end else if (rd_flag) begin
            rdata_next = flags;
        end else if (rd_mask) begin
            rdata_next = mask;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            rdata_reg <= CTT_RDATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_out = rdata_reg;

    a_low_counts: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R2]
        tick_rise |=> (low_reg == $past(low_reg) + 4'h1))
        else $error("low nibble did not advance on tick");
    a_low_still: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R1]
        !tick_rise |=> (low_reg == $past(low_reg)))
        else $error("low nibble moved without tick");
    a_hold_starts: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R5]
        rd_low |=> (state_reg == CTT_ST_HOLD))
        else $error("low read did not start hold");
    a_high_frozen: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R5]
        (state_reg == CTT_ST_HOLD && !hold_end) |=> (high_reg == $past(high_reg)))
        else $error("high nibble moved during hold");
    a_hold_ends_read: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R6]
        (state_reg == CTT_ST_HOLD && rd_high && !rd_low) |=> (state_reg == CTT_ST_FREE))
        else $error("high read did not end hold");
    a_hold_bounded: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R5]
        hold_cnt_reg < 16'(HOLD_CYCLES))
        else $error("hold exceeded its maximum");
    a_carry_applied: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R6]
        (state_reg == CTT_ST_HOLD && hold_end && !rd_low && pend_reg && !carry)
        |=> (high_reg == $past(high_reg) + 4'h1))
        else $error("deferred carry lost at end of hold");
    a_low_read_data: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R3]
        rd_low |=> (rdata_out == $past(low_reg)))
        else $error("low nibble read data wrong");
    a_tap_fall_flag: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R10]
        tap_fall[3] |=> flags[3])
        else $error("1 Hz falling edge did not set its flag");

    // read path: data stands one cycle, zero otherwise
    a_rdata_idle: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R3] [R4]
        !rd_in |=> (rdata_out == CTT_RDATA_RST))
        else $error("read data not zero outside a read");
    a_high_read_data: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R4]
        rd_high |=> (rdata_out == $past(high_reg)))
        else $error("high nibble read data wrong");
    a_flag_read_data: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R10]
        rd_flag |=> (rdata_out == $past(flags)))
        else $error("flag read data wrong");

    // high nibble outside a hold
    a_free_carry: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R4]
        (state_reg == CTT_ST_FREE && carry && !rd_low)
        |=> (high_reg == $past(high_reg) + 4'h1))
        else $error("carry out of low nibble not applied");
    a_free_still: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R4]
        (state_reg == CTT_ST_FREE && !carry) |=> (high_reg == $past(high_reg)))
        else $error("high nibble moved without a carry");
    a_low_read_defers: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R5]
        (state_reg == CTT_ST_FREE && rd_low && carry)
        |=> (high_reg == $past(high_reg) && pend_reg))
        else $error("carry in the low read cycle not deferred");
    a_high_first_free: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R7]
        (state_reg == CTT_ST_FREE && rd_high) |=> (state_reg == CTT_ST_FREE))
        else $error("high read started a hold");

    // hold exit
    a_hold_times_out: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R5]
        (state_reg == CTT_ST_HOLD && !rd_low && hold_cnt_reg == 16'(HOLD_CYCLES - 1))
        |=> (state_reg == CTT_ST_FREE))
        else $error("hold outlived its maximum");
    a_no_stale_pend: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R6]
        (state_reg == CTT_ST_FREE) |-> !pend_reg)
        else $error("deferred carry left over after hold");

    // flags and mask
    a_mask_write: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R11]
        wr_mask |=> (mask == $past(wdata_in)))
        else $error("mask write not applied");
    a_flag_clear: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R13]
        (wr_flag && tap_fall == 4'h0)
        |=> ((flags & $past(wdata_in)) == 4'h0))
        else $error("written flag bits not cleared");
    generate
        for (t = 0; t < CTT_TAPS; t++) begin : g_tap_chk
            a_tap_flag: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R10]
                tap_fall[t] |=> flags[t])
                else $error("tap falling edge did not set its flag");
        end
    endgenerate
endmodule // ctt_timer

// ==== verification/tb.sv ====
`timescale 1ns/100ps
module tb;
    import ctt_pkg::*;
    // short hold so the timeout path is reached quickly
    localparam int unsigned HOLD = 40;
    logic ref_clk_in, rstn_in, crystal_tick_in, wr_in, rd_in, irq_out;
    logic [15:0] addr_in;
    logic [3:0] wdata_in, rdata_out, got, exp_flags, m, hi;
    logic [7:0] exp_cnt, nxt, fell;
    int mismatches, checked, cycles, seed, n;

    ctt_timer #(.HOLD_CYCLES(HOLD)) ctt_timer_inst (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .crystal_tick_in(crystal_tick_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .irq_out(irq_out)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    task automatic report_and_stop;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [3:0] g, input logic [3:0] e, input string s);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, s, g, e);
        end
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 got = rdata_out;
    endtask

    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask

    // expected count and flags after one tick
    task automatic advance;
        nxt = exp_cnt + 8'h01;
        fell = exp_cnt & ~nxt;
        exp_flags = exp_flags | {fell[7], fell[6], fell[4], fell[2]};
        exp_cnt = nxt;
    endtask

    // one prescaler period, four clocks high and four low, well above the minimum
    task automatic tick;
        @(posedge ref_clk_in);
        crystal_tick_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        crystal_tick_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        advance();
    endtask

    task automatic to_low_max;
        do tick(); while (exp_cnt[3:0] != 4'hF);
    endtask

    initial begin
        seed = 53434;
        rstn_in = 1'b0;
        crystal_tick_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 16'h0000;
        wdata_in = 4'h0;
        exp_cnt = 8'h00;
        exp_flags = 4'h0;
        repeat (5) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        rd(CTT_ADDR_LOW);
        chk(got, 4'h0, "low after reset");
        rd(CTT_ADDR_HIGH);
        chk(got, 4'h0, "high after reset");
        rd(CTT_ADDR_FLAG);
        chk(got, 4'h0, "flags after reset");
        rd(CTT_ADDR_MASK);
        chk(got, 4'h0, "mask after reset");
        chk({3'h0, irq_out}, 4'h0, "irq after reset");
        // random bursts of ticks, low nibble read before high
        for (int i = 0; i < 12; i++) begin
            n = ($random(seed) & 15) + 1;
            repeat (n) tick();
            rd(CTT_ADDR_LOW);
            chk(got, exp_cnt[3:0], "low nibble");
            rd(CTT_ADDR_HIGH);
            chk(got, exp_cnt[7:4], "high nibble");
            rd(CTT_ADDR_FLAG);
            chk(got, exp_flags, "flags masked off");
            chk({3'h0, irq_out}, 4'h0, "irq while masked");
        end
        // carry during hold, ended by the high read
        to_low_max();
        rd(CTT_ADDR_LOW);
        hi = exp_cnt[7:4];
        tick();
        rd(CTT_ADDR_HIGH);
        chk(got, hi, "held high");
        rd(CTT_ADDR_HIGH);
        chk(got, exp_cnt[7:4], "deferred carry");
        // low read taken in the very cycle of the carry
        to_low_max();
        hi = exp_cnt[7:4];
        @(posedge ref_clk_in);
        crystal_tick_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= CTT_ADDR_LOW;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 got = rdata_out;
        chk(got, 4'hF, "low in carry cycle");
        advance();
        @(posedge ref_clk_in);
        crystal_tick_in <= 1'b0;
        rd(CTT_ADDR_HIGH);
        chk(got, hi, "high held over carry");
        rd(CTT_ADDR_HIGH);
        chk(got, exp_cnt[7:4], "carry after pair");
        // carry during hold, ended by the timeout
        to_low_max();
        rd(CTT_ADDR_LOW);
        tick();
        repeat (HOLD + 10) @(posedge ref_clk_in);
        rd(CTT_ADDR_HIGH);
        chk(got, exp_cnt[7:4], "hold expired");
        // high first never freezes the low nibble
        rd(CTT_ADDR_HIGH);
        tick();
        rd(CTT_ADDR_LOW);
        chk(got, exp_cnt[3:0], "low free");
        wr(CTT_ADDR_LOW, 4'hF);
        rd(CTT_ADDR_LOW);
        chk(got, exp_cnt[3:0], "low is read only");
        rd(16'hFF7D);
        chk(got, 4'h0, "unmapped read");
        // run past a wrap so every tap falls
        do tick(); while (exp_cnt != 8'h00);
        rd(CTT_ADDR_FLAG);
        chk(got, exp_flags, "all flags");
        for (int i = 0; i < 8; i++) begin
            m = $random(seed);
            wr(CTT_ADDR_MASK, m);
            rd(CTT_ADDR_MASK);
            chk(got, m, "mask readback");
            chk({3'h0, irq_out}, {3'h0, |(exp_flags & m)}, "irq vs mask");
        end
        wr(CTT_ADDR_MASK, 4'hF);
        wr(CTT_ADDR_FLAG, 4'h5);
        exp_flags = exp_flags & 4'hA;
        rd(CTT_ADDR_FLAG);
        chk(got, exp_flags, "partial clear");
        chk({3'h0, irq_out}, {3'h0, |exp_flags}, "irq after partial");
        wr(CTT_ADDR_FLAG, 4'hF);
        exp_flags = 4'h0;
        rd(CTT_ADDR_FLAG);
        chk(got, 4'h0, "full clear");
        chk({3'h0, irq_out}, 4'h0, "irq cleared");
        repeat (8) tick();
        rd(CTT_ADDR_FLAG);
        chk(got, exp_flags, "32 Hz tap with mask on");
        chk({3'h0, irq_out}, {3'h0, |exp_flags}, "irq raised");
        report_and_stop();
    end
endmodule // tb
